// file: hw/pos_pkg.sv
// types and shared arithmetic of the pulse output source selector
`include "pos_regs.svh"

package pos_pkg;

	// ------------------------------------------------------------------
	// power carriers: index 0 is phase A, set index is the source code
	// ------------------------------------------------------------------
	typedef logic signed [`POS_PWR_W-1:0] pos_pwr_t;
	typedef logic signed [`POS_SUM_W-1:0] pos_sum_t;
	typedef pos_pwr_t [2:0]               pos_phase_pwr_t;
	typedef pos_phase_pwr_t [4:0]         pos_pwr_set_t;

	// ------------------------------------------------------------------
	// module state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [`POS_REG_W-1:0] cfg;
		logic [`POS_REG_W-1:0] comp;
		logic [31:0]           rdata;
		logic                  err;
	} pos_reg_state_t;

	typedef struct packed {
		pos_sum_t sum;
		logic     active;
	} pos_sel_state_t;

	// sum of the phases whose mask bit is set, sign extended
	function automatic pos_sum_t pos_masked_sum(pos_phase_pwr_t p,
		logic [2:0] m);
		pos_sum_t acc;
		acc = '0;
		for (int i = 0; i < 3; i++)
		begin
			if (m[i])
				acc = acc + `POS_SUM_W'(p[i]);
		end
		return acc;
	endfunction : pos_masked_sum

endpackage : pos_pkg

// file: hw/pos_pulse_source_select.sv
// pulse output source selector: apb registers and two source paths
//
// Overview of operation
// RL1: first selector in bits 2:0, reset 000; 000 picks summed total active.
// RL2: first selector 001 picks summed total reactive power.
// RL3: first selector 010 picks summed apparent power.
// RL4: first selector 011 picks summed fundamental active power.
// RL5: first selector 100 picks summed fundamental reactive power.
// RL6: first selector codes 101, 110, 111 stop the first output entirely.
// RL7: second selector in bits 5:3, reset 001, same code mapping.
// RL8: a phase enters each sum only when its mask bit is set.
//
// The implementer's own choice: the APB register port.
`include "pos_regs.svh"

module pos_pulse_source_select #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// per-phase power quantities from the metering datapath
	input  wire pos_pkg::pos_pwr_set_t power_in,
	// selected sums for the pulse generators
	output pos_pkg::pos_sum_t          first_pulse_sum,
	output logic                       first_pulse_enable,
	output pos_pkg::pos_sum_t          second_pulse_sum,
	output logic                       second_pulse_enable
);

	pos_pkg::pos_reg_state_t state_q;
	pos_pkg::pos_reg_state_t state_d;

	logic [2:0] first_pulse_source_code;
	logic [2:0] second_pulse_source_code;
	logic [2:0] first_pulse_phase_mask;
	logic [2:0] second_pulse_phase_mask;
	logic       hit_cfg;
	logic       hit_comp;
	logic       setup;
	logic       access;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// byte-lane merge; only lanes 0 and 1 carry register bits
	function automatic logic [`POS_REG_W-1:0] merge_lanes(
		logic [`POS_REG_W-1:0] old_val,
		logic [31:0]           wdata,
		logic [3:0]            strb,
		logic [`POS_REG_W-1:0] wmask);
		logic [`POS_REG_W-1:0] v;
		v = old_val;
		if (strb[0])
			v[7:0] = wdata[7:0];
		if (strb[1])
			v[15:8] = wdata[15:8];
		return v & wmask;
	endfunction : merge_lanes

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	// full compare: misaligned or foreign addresses are unmapped
	assign hit_cfg  = paddr == ADDR_W'(`POS_CFG_OFF);
	assign hit_comp = paddr == ADDR_W'(`POS_COMP_OFF);
	assign setup    = psel && !penable;
	assign access   = psel && penable;

	// ------------------------------------------------------------------
	// register file
	// ------------------------------------------------------------------
	// read data and error are latched in setup so prdata is a flop
	always_comb
	begin
		state_d = state_q;
		if (setup)
		begin
			state_d.err = !(hit_cfg || hit_comp);
			if (hit_cfg)
				state_d.rdata = {16'h0000, state_q.cfg};
			else if (hit_comp)
				state_d.rdata = {16'h0000, state_q.comp};
			else
				state_d.rdata = 32'h0000_0000;
		end
		// writes land only at the completing access edge
		if (access && pwrite && !state_q.err)
		begin
			if (hit_cfg)
				state_d.cfg = merge_lanes(state_q.cfg, pwdata, pstrb,
					`POS_CFG_WMASK); // RL1 RL7
			if (hit_comp)
				state_d.comp = merge_lanes(state_q.comp, pwdata, pstrb,
					`POS_COMP_WMASK); // RL8
		end
	end

	// state register; reset codes 000 and 001, all phases included
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q       <= '0;
			state_q.cfg   <= `POS_CFG_RST; // RL1 RL7
			state_q.comp  <= `POS_COMP_RST;
		end
		else
			state_q <= state_d;
	end

	// ------------------------------------------------------------------
	// bus answers
	// ------------------------------------------------------------------
	// no wait states: every access phase completes at once
	assign pready  = 1'b1;
	assign prdata  = state_q.rdata;
	assign pslverr = access && state_q.err;

	// ------------------------------------------------------------------
	// field extraction
	// ------------------------------------------------------------------
	assign first_pulse_source_code  =
		state_q.cfg[`POS_SEL1_LSB +: `POS_SEL_W]; // RL1
	assign second_pulse_source_code =
		state_q.cfg[`POS_SEL2_LSB +: `POS_SEL_W]; // RL7
	assign first_pulse_phase_mask   =
		state_q.comp[`POS_MASK1_LSB +: 3]; // RL8
	assign second_pulse_phase_mask  =
		state_q.comp[`POS_MASK2_LSB +: 3]; // RL8

	// ------------------------------------------------------------------
	// source paths
	// ------------------------------------------------------------------
	// both outputs are instances of one decoder module so the mapping cannot drift apart
	pos_sum_sel u_first (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.source_code (first_pulse_source_code),
		.phase_mask  (first_pulse_phase_mask),
		.power_in    (power_in),
		.sum_q       (first_pulse_sum),
		.active_q    (first_pulse_enable)
	);

	// second path, same code mapping
	pos_sum_sel u_second (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.source_code (second_pulse_source_code), // RL7
		.phase_mask  (second_pulse_phase_mask),
		.power_in    (power_in),
		.sum_q       (second_pulse_sum),
		.active_q    (second_pulse_enable)
	);

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	first_code_rst_a: assert property (@(posedge ref_clk) disable iff (rst) // RL1
		$past(rst) |-> first_pulse_source_code == 3'h0
		##1 first_pulse_enable)
		else $error("first selector reset value wrong");
	second_code_rst_a: assert property (@(posedge ref_clk) // RL7
		disable iff (rst)
		$past(rst) |-> second_pulse_source_code == 3'h1
		##1 second_pulse_enable)
		else $error("second selector reset value wrong");
	cfg_write_a: assert property (@(posedge ref_clk) disable iff (rst) // RL1
		access && pwrite && hit_cfg && pstrb[0] |=>
		first_pulse_source_code == $past(pwdata[2:0])
		&& second_pulse_source_code == $past(pwdata[5:3]))
		else $error("selector write did not take effect");
	mask_route_a: assert property (@(posedge ref_clk) disable iff (rst) // RL8
		access && pwrite && hit_comp && pstrb[0] && pwdata[5:3] == 3'h0
		##1 second_pulse_source_code <= 3'h4 |=> second_pulse_sum == '0)
		else $error("cleared second mask still sums phases");
	// a phase mask write shows in both fields one edge later
	mask_write_a: assert property (@(posedge ref_clk) // RL8
		disable iff (rst)
		access && pwrite && hit_comp && pstrb[0] |=>
		first_pulse_phase_mask == $past(pwdata[2:0])
		&& second_pulse_phase_mask == $past(pwdata[5:3]))
		else $error("phase mask write did not take effect");
	// a refused transfer must leave both registers as they were
	refused_write_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		access && pwrite && state_q.err |=>
		$stable(state_q.cfg) && $stable(state_q.comp))
		else $error("refused write changed a register");
	// unmapped address answers with an error in its access cycle
	unmapped_err_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		setup && !(hit_cfg || hit_comp) ##1 access |-> pslverr)
		else $error("unmapped address not refused");
	// unimplemented bits read back as zero
	rdata_upper_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		access |-> prdata[31:6] == 26'h0)
		else $error("unimplemented bits read nonzero");
	// codes 000 to 100 keep the first output running
	first_enable_a: assert property (@(posedge ref_clk) // RL1 RL2 RL3 RL4 RL5
		disable iff (rst)
		first_pulse_source_code <= 3'h4 |=> first_pulse_enable)
		else $error("valid first code gave no pulses");
	// the same codes keep the second output running
	second_enable_a: assert property (@(posedge ref_clk) // RL7
		disable iff (rst)
		second_pulse_source_code <= 3'h4 |=> second_pulse_enable)
		else $error("valid second code gave no pulses");
	// reserved codes stop the second output as they stop the first
	second_reserved_a: assert property (@(posedge ref_clk) // RL7
		disable iff (rst)
		second_pulse_source_code > 3'h4 |=>
		!second_pulse_enable && second_pulse_sum == '0)
		else $error("reserved second code still drives pulses");

endmodule : pos_pulse_source_select

// file: hw/pos_regs.svh
// register offsets, field positions, reset values and codes of the selector
`ifndef POS_REGS_SVH
`define POS_REGS_SVH

// ----------------------------------------------------------------------
// data widths
// ----------------------------------------------------------------------
`define POS_PWR_W       24
`define POS_SUM_W       26
`define POS_REG_W       16
`define POS_SEL_W       3

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define POS_CFG_OFF     16'hE610
`define POS_COMP_OFF    16'hE614

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define POS_SEL1_LSB    0
`define POS_SEL2_LSB    3
`define POS_MASK1_LSB   0
`define POS_MASK2_LSB   3
`define POS_CFG_RST     16'h0008
`define POS_COMP_RST    16'h003F
`define POS_CFG_WMASK   16'h003F
`define POS_COMP_WMASK  16'h003F

// ----------------------------------------------------------------------
// source codes
// ----------------------------------------------------------------------
`define POS_CODE_TACT   3'h0
`define POS_CODE_TREACT 3'h1
`define POS_CODE_APP    3'h2
`define POS_CODE_FACT   3'h3
`define POS_CODE_FREACT 3'h4

`endif

// file: hw/pos_sum_sel.sv
// one pulse output: picks the power quantity and sums the masked phases
`include "pos_regs.svh"

module pos_sum_sel (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	// configuration
	input  wire logic [2:0]            source_code,
	input  wire logic [2:0]            phase_mask,
	// power quantities
	input  wire pos_pkg::pos_pwr_set_t power_in,
	// selected sum
	output pos_pkg::pos_sum_t          sum_q,
	output logic                       active_q
);

	pos_pkg::pos_sel_state_t state_q;
	pos_pkg::pos_sel_state_t state_d;
	pos_pkg::pos_sum_t       exp_sum [5];

	// ------------------------------------------------------------------
	// source decode
	// ------------------------------------------------------------------
	// reserved codes must stop the output, not fall back to a default
	always_comb
	begin
		state_d = state_q;
		state_d.active = 1'b1;
		case (source_code)
			`POS_CODE_TACT:   state_d.sum = pos_pkg::pos_masked_sum(
				power_in[0], phase_mask); // RL1
			`POS_CODE_TREACT: state_d.sum = pos_pkg::pos_masked_sum(
				power_in[1], phase_mask); // RL2
			`POS_CODE_APP:    state_d.sum = pos_pkg::pos_masked_sum(
				power_in[2], phase_mask); // RL3
			`POS_CODE_FACT:   state_d.sum = pos_pkg::pos_masked_sum(
				power_in[3], phase_mask); // RL4
			`POS_CODE_FREACT: state_d.sum = pos_pkg::pos_masked_sum(
				power_in[4], phase_mask); // RL5
			default:
			begin
				state_d.sum = '0; // RL6
				state_d.active = 1'b0; // RL6
			end
		endcase
	end

	// state register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign sum_q    = state_q.sum;
	assign active_q = state_q.active;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	// expected sums per quantity, read only by the checks
	always_comb
	begin
		for (int k = 0; k < 5; k++)
			exp_sum[k] = pos_pkg::pos_masked_sum(power_in[k], phase_mask);
	end

	total_active_a: assert property (@(posedge ref_clk) disable iff (rst) // RL1
		source_code == `POS_CODE_TACT |=>
		active_q && sum_q == $past(exp_sum[0]))
		else $error("total active sum not selected");
	total_reactive_a: assert property (@(posedge ref_clk) disable iff (rst) // RL2
		source_code == `POS_CODE_TREACT |=>
		active_q && sum_q == $past(exp_sum[1]))
		else $error("total reactive sum not selected");
	apparent_sum_a: assert property (@(posedge ref_clk) disable iff (rst) // RL3
		source_code == `POS_CODE_APP |=>
		active_q && sum_q == $past(exp_sum[2]))
		else $error("apparent sum not selected");
	fund_active_a: assert property (@(posedge ref_clk) disable iff (rst) // RL4
		source_code == `POS_CODE_FACT |=>
		active_q && sum_q == $past(exp_sum[3]))
		else $error("fundamental active sum not selected");
	fund_reactive_a: assert property (@(posedge ref_clk) disable iff (rst) // RL5
		source_code == `POS_CODE_FREACT |=>
		active_q && sum_q == $past(exp_sum[4]))
		else $error("fundamental reactive sum not selected");
	reserved_off_a: assert property (@(posedge ref_clk) disable iff (rst) // RL6
		source_code > `POS_CODE_FREACT |=> !active_q && sum_q == '0)
		else $error("reserved code still drives the output");
	empty_mask_a: assert property (@(posedge ref_clk) disable iff (rst) // RL8
		phase_mask == 3'h0 |=> sum_q == '0)
		else $error("empty phase mask gives a nonzero sum");

endmodule : pos_sum_sel

// file: tb/pos_pulse_source_select_tb.sv
// self-checking bench of the pulse output source selector
`include "pos_regs.svh"

module pos_pulse_source_select_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------------
	logic                  ref_clk   = 1'b0;
	logic                  rst       = 1'b1;
	logic                  psel      = 1'b0;
	logic                  penable   = 1'b0;
	logic                  pwrite    = 1'b0;
	logic [15:0]           paddr     = 16'h0000;
	logic [31:0]           pwdata    = 32'h0000_0000;
	logic [3:0]            pstrb     = 4'hF;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	pos_pkg::pos_pwr_set_t power_in  = '0;
	pos_pkg::pos_sum_t     sum1;
	pos_pkg::pos_sum_t     sum2;
	logic                  en1;
	logic                  en2;
	logic [31:0]           lfsr_q    = 32'h9E37_8DEA;
	logic [31:0]           rd;
	logic                  err_seen;
	logic [31:0]           r;
	logic [2:0]            c1, c2, m1, m2;
	int                    error_cnt = 0;
	int                    checks    = 0;
	int                    cyc       = 0;

	pos_pulse_source_select #(.ADDR_W(16)) uut (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_in(power_in), .first_pulse_sum(sum1),
		.first_pulse_enable(en1), .second_pulse_sum(sum2),
		.second_pulse_enable(en2)
	);

	// free-running clock, 100 MHz
	always #5 ref_clk = ~ref_clk;

	// hang guard: the whole run needs about 115 cycles
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic rnd(output logic [31:0] v);
		lfsr_q = lfsr_next(lfsr_q);
		v = lfsr_q;
	endtask : rnd

	// reserved codes give an empty sum, the rest add masked phases
	function automatic pos_pkg::pos_sum_t exp_sum(logic [2:0] code,
		logic [2:0] m);
		pos_pkg::pos_sum_t acc;
		acc = '0;
		if (code > 3'h4)
			return acc;
		for (int p = 0; p < 3; p++)
			if (m[p])
				acc = acc + pos_pkg::pos_sum_t'(power_in[code][p]);
		return acc;
	endfunction : exp_sum

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask : check

	// new random power on every phase and quantity
	task automatic new_power();
		logic [31:0] v;
		for (int k = 0; k < 5; k++)
			for (int p = 0; p < 3; p++)
			begin
				rnd(v);
				power_in[k][p] <= v[23:0];
			end
	endtask : new_power

	// one apb transfer, entered just after a rising edge; idles one cycle
	task automatic apb(logic wr, logic [15:0] a, logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd       = prdata;
		err_seen = pslverr;
		if (n >= 20)
			check("pready", 32'h1, 32'h0);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	// outputs looked at mid-cycle, where they are settled
	task automatic check_out(logic [2:0] a1, b1, a2, b2);
		@(negedge ref_clk);
		check("first sum", 32'(exp_sum(a1, b1)), 32'(sum1));
		check("first enable", {31'h0, a1 < 3'h5}, {31'h0, en1});
		check("second sum", 32'(exp_sum(a2, b2)), 32'(sum2));
		check("second enable", {31'h0, a2 < 3'h5}, {31'h0, en2});
		@(posedge ref_clk);
	endtask : check_out

	task automatic report_and_stop();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		new_power();
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check_out(3'h0, 3'h7, 3'h1, 3'h7);
		apb(1'b0, `POS_CFG_OFF, 32'h0);
		check("cfg reset", 32'h0000_0008, rd);
		check("cfg slverr", 32'h0, {31'h0, err_seen});
		apb(1'b0, `POS_COMP_OFF, 32'h0);
		check("mask reset", 32'h0000_003F, rd);
		// every code on both outputs, random masks, an empty mask once on each output
		for (int i = 0; i < 8; i++)
		begin
			rnd(r);
			c1 = i[2:0];
			c2 = 3'(7 - i);
			m1 = (i == 1) ? 3'h0 : r[2:0];
			m2 = (i == 6) ? 3'h0 : r[5:3];
			new_power();
			apb(1'b1, `POS_CFG_OFF, {r[31:6], c2, c1});
			apb(1'b1, `POS_COMP_OFF, {r[31:6], m2, m1});
			apb(1'b0, `POS_CFG_OFF, 32'h0);
			check("cfg readback", {26'h0, c2, c1}, rd);
			check_out(c1, m1, c2, m2);
		end
		// strobes off and an unmapped address: both writes are dropped
		pstrb <= 4'h0;
		apb(1'b1, `POS_CFG_OFF, 32'h0000_0015);
		pstrb <= 4'hF;
		apb(1'b1, 16'hE618, 32'h0000_0015);
		check("unmapped slverr", 32'h1, {31'h0, err_seen});
		check("unmapped data", 32'h0, rd);
		apb(1'b0, `POS_CFG_OFF, 32'h0);
		check("cfg kept", 32'h0000_0007, rd);
		// reset in mid-run brings back the reset codes and masks
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check_out(3'h0, 3'h7, 3'h1, 3'h7);
		apb(1'b0, `POS_CFG_OFF, 32'h0);
		check("cfg after reset", 32'h0000_0008, rd);
		report_and_stop();
	end

endmodule : pos_pulse_source_select_tb
